// File: slpc_map.vh
`ifndef SLPC_MAP_VH
`define SLPC_MAP_VH

// Register byte offsets
`define SLPC_CTRL_ADDR 8'h00
`define SLPC_STAT_ADDR 8'h04
`define SLPC_TXDATA_ADDR 8'h08
`define SLPC_RXDATA_ADDR 8'h0c
`define SLPC_MSGEND_ADDR 8'h10
`define SLPC_CONFIG_ADDR 8'h14
`define SLPC_GRAPH_ADDR 8'h18
`define SLPC_ERRSEND_ADDR 8'h1c

// Control field positions
`define SLPC_CTRL_FLOW 0
`define SLPC_CTRL_TWOSTOP 1
`define SLPC_CTRL_SRE 2
`define SLPC_CTRL_HC_LO 4
`define SLPC_CTRL_HC_HI 5

// Status field positions (sticky bits 2,3,6,7 clear on write one)
`define SLPC_ST_TXBUSY 0
`define SLPC_ST_RXVALID 1
`define SLPC_ST_PARERR 2
`define SLPC_ST_FRAMEERR 3
`define SLPC_ST_PAUSED 4
`define SLPC_ST_OFFLINE 5
`define SLPC_ST_LINEEND 6
`define SLPC_ST_OVERRUN 7

// Reset values
`define SLPC_CTRL_RESET 8'h00
`define SLPC_EVENT_BYTE 8'h61

// Characters
`define SLPC_CHAR_CR 8'h0d
`define SLPC_CHAR_LF 8'h0a
`define SLPC_CHAR_XON 8'h11
`define SLPC_CHAR_XOFF 8'h13
`define SLPC_CHAR_ESC 8'h1b
`define SLPC_CHAR_L 8'h4c
`define SLPC_CHAR_Y 8'h59

// Rate code meaning off line
`define SLPC_OFFLINE_CODE 4'hf

// Clock and oversampling
`define SLPC_CLK_HZ 50000000
`define SLPC_OVERSAMPLE 16

// Oversample divisors: round(clk / (baud * 16))
`define SLPC_DIV_50 17'd62500
`define SLPC_DIV_75 17'd41667
`define SLPC_DIV_110 17'd28409
`define SLPC_DIV_134 17'd23234
`define SLPC_DIV_150 17'd20833
`define SLPC_DIV_300 17'd10417
`define SLPC_DIV_600 17'd5208
`define SLPC_DIV_1200 17'd2604
`define SLPC_DIV_1800 17'd1736
`define SLPC_DIV_2000 17'd1563
`define SLPC_DIV_2400 17'd1302
`define SLPC_DIV_3600 17'd868
`define SLPC_DIV_4800 17'd651
`define SLPC_DIV_7200 17'd434
`define SLPC_DIV_9600 17'd326

`endif

// File: slpc_serial_port.v
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "slpc_map.vh"

module slpc_serial_port #(
   parameter [7:0] EVENT_BYTE = `SLPC_EVENT_BYTE
) (
   input wire clk,
   input wire sys_rst,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [3:0] swBaud,
   input wire swParEnable,
   input wire [1:0] swParSelect,
   input wire swCrLf,
   input wire [1:0] swHardcopy,
   input wire rxd,
   output reg txd,
   output reg requestActive
);

   localparam TX_IDLE = 2'd0;
   localparam TX_SHIFT = 2'd1;
   localparam RX_IDLE = 3'd0;
   localparam RX_START = 3'd1;
   localparam RX_DATA = 3'd2;
   localparam RX_STOP = 3'd3;
   function [16:0] rateDivisor;
      input [3:0] code;
      begin
         case (code)
            4'h0: rateDivisor = `SLPC_DIV_50;
            4'h1: rateDivisor = `SLPC_DIV_75;
            4'h2: rateDivisor = `SLPC_DIV_110;
            4'h3: rateDivisor = `SLPC_DIV_134;
            4'h4: rateDivisor = `SLPC_DIV_150;
            4'h5: rateDivisor = `SLPC_DIV_300;
            4'h6: rateDivisor = `SLPC_DIV_600;
            4'h7: rateDivisor = `SLPC_DIV_1200;
            4'h8: rateDivisor = `SLPC_DIV_1800;
            4'h9: rateDivisor = `SLPC_DIV_2000;
            4'ha: rateDivisor = `SLPC_DIV_2400;
            4'hb: rateDivisor = `SLPC_DIV_3600;
            4'hc: rateDivisor = `SLPC_DIV_4800;
            4'hd: rateDivisor = `SLPC_DIV_7200;
            default: rateDivisor = `SLPC_DIV_9600;
         endcase
      end
   endfunction
   // Parity bit for seven data bits; sel[0] is switch 6, sel[1] switch 7
   function parityBit;
      input [6:0] data;
      input [1:0] sel;
      begin
         if (sel[1])
            parityBit = ~sel[0];
         else
            parityBit = (^data) ^ ~sel[0];
      end
   endfunction

   reg cfgLoaded;
   reg [3:0] cfgBaud;
   reg cfgParEnable;
   reg [1:0] cfgParSelect;
   reg cfgCrLf;
   reg [1:0] swHardcopyLatch;
   reg flowEnable;
   reg twoStop;
   reg serviceRequestEnable;
   reg [1:0] hardcopy;
   reg parErr;
   reg frameErr;
   reg lineEnd;
   reg overrun;
   reg paused;
   reg rxValid;
   reg [7:0] rxData;
   reg wrPending;
   reg [7:0] wrAddr;
   reg dataPending;
   reg [7:0] dataByte;
   reg errPending;
   reg [7:0] errByte;
   reg eventPending;
   reg [1:0] termLeft;
   reg [16:0] divCount;
   reg tick;
   reg [1:0] txState;
   reg [10:0] txShift;
   reg [3:0] txBits;
   reg [3:0] txTicks;
   reg txIsStatus;
   reg [2:0] rxState;
   reg [7:0] rxShift;
   reg [2:0] rxBits;
   reg [3:0] rxTicks;
   reg rxPrev;
   wire offline = (cfgBaud == `SLPC_OFFLINE_CODE);
   wire addrPhase = hsel && hready && htrans[1];
   wire [7:0] statusWord = {overrun, lineEnd, offline, paused, frameErr, parErr, rxValid, txState != TX_IDLE};
   wire [7:0] ctrlWord = {2'b00, hardcopy, 1'b0, serviceRequestEnable, twoStop, flowEnable};
   wire [7:0] configWord = {cfgBaud[3], cfgCrLf, cfgParSelect, cfgParEnable, cfgBaud[2:0]};
   wire [7:0] graphicsCode = cfgParEnable ? `SLPC_CHAR_L : `SLPC_CHAR_Y;
   wire [7:0] rxChar = cfgParEnable ? {1'b0, rxShift[6:0]} : rxShift;
   wire rxParBad = cfgParEnable && (rxShift[7] != parityBit(rxShift[6:0], cfgParSelect));
   wire rxFlowChar = flowEnable && (rxChar == `SLPC_CHAR_XON || rxChar == `SLPC_CHAR_XOFF);
   wire rxDone = tick && rxState == RX_STOP && rxTicks == 4'd15;
   wire rxGood = rxDone && rxd;
   wire rxLineEnd = cfgCrLf ? (rxChar == `SLPC_CHAR_LF) : (rxChar == `SLPC_CHAR_CR);
   // Frame builder: start, eight bits, stop(s), idle high
   wire [7:0] txPayload = errPending ? errByte :
      eventPending ? EVENT_BYTE :
      (termLeft != 2'd0) ? ((termLeft == 2'd1 && cfgCrLf) ? `SLPC_CHAR_LF : `SLPC_CHAR_CR) :
      dataByte;
   wire [7:0] txBitsOut = cfgParEnable ?
      {parityBit(txPayload[6:0], cfgParSelect), txPayload[6:0]} : txPayload;
   wire txAny = errPending || eventPending || termLeft != 2'd0 || dataPending;
   // Status bytes bypass the pause; frames begin on a tick so the start bit is whole
   wire txStart = tick && cfgLoaded && !offline && txState == TX_IDLE &&
      (errPending || eventPending || (!paused && txAny));
   // Switch capture, once after reset release
   always @(posedge clk) begin
      if (sys_rst) begin
         cfgLoaded <= 1'b0;
         cfgBaud <= 4'h0;
         cfgParEnable <= 1'b0;
         cfgParSelect <= 2'b00;
         cfgCrLf <= 1'b0;
      end else if (!cfgLoaded) begin
         cfgLoaded <= 1'b1;
         cfgBaud <= swBaud;
         cfgParEnable <= swParEnable;
         cfgParSelect <= swParSelect;
         cfgCrLf <= swCrLf;
      end
   end
   // Oversample tick generator
   always @(posedge clk) begin
      if (sys_rst || !cfgLoaded || offline) begin
         divCount <= 17'd0;
         tick <= 1'b0;
      end else if (divCount == rateDivisor(cfgBaud) - 17'd1) begin
         divCount <= 17'd0;
         tick <= 1'b1;
      end else begin
         divCount <= divCount + 17'd1;
         tick <= 1'b0;
      end
   end
   // AHB-Lite slave, zero wait states
   always @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPending <= 1'b0;
         wrAddr <= 8'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPending <= addrPhase && hwrite;
         if (addrPhase)
            wrAddr <= haddr;
         if (addrPhase && !hwrite) begin
            case (haddr)
               `SLPC_CTRL_ADDR: hrdata <= {24'h0, ctrlWord};
               `SLPC_STAT_ADDR: hrdata <= {24'h0, statusWord};
               `SLPC_RXDATA_ADDR: hrdata <= {24'h0, rxData};
               `SLPC_CONFIG_ADDR: hrdata <= {22'h0, swHardcopyLatch, configWord};
               `SLPC_GRAPH_ADDR: hrdata <= {16'h0, `SLPC_CHAR_ESC, graphicsCode};
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end
   // Control and transmit requests
   always @(posedge clk) begin
      if (sys_rst) begin
         flowEnable <= 1'b0;
         twoStop <= 1'b0;
         serviceRequestEnable <= 1'b0;
         hardcopy <= 2'b00;
         swHardcopyLatch <= 2'b00;
         dataPending <= 1'b0;
         dataByte <= 8'h0;
         errPending <= 1'b0;
         errByte <= 8'h0;
         eventPending <= 1'b0;
         termLeft <= 2'd0;
      end else begin
         if (!cfgLoaded) begin
            hardcopy <= swHardcopy;
            swHardcopyLatch <= swHardcopy;
         end
         if (wrPending && wrAddr == `SLPC_CTRL_ADDR) begin
            flowEnable <= hwdata[`SLPC_CTRL_FLOW];
            twoStop <= hwdata[`SLPC_CTRL_TWOSTOP];
            serviceRequestEnable <= hwdata[`SLPC_CTRL_SRE];
            hardcopy <= hwdata[`SLPC_CTRL_HC_HI:`SLPC_CTRL_HC_LO];
         end
         if (txStart) begin
            if (errPending)
               errPending <= 1'b0;
            else if (eventPending)
               eventPending <= 1'b0;
            else if (termLeft != 2'd0)
               termLeft <= termLeft - 2'd1;
            else
               dataPending <= 1'b0;
         end
         if (wrPending && wrAddr == `SLPC_TXDATA_ADDR && !dataPending && termLeft == 2'd0) begin
            dataPending <= 1'b1;
            dataByte <= hwdata[7:0];
         end
         if (wrPending && wrAddr == `SLPC_MSGEND_ADDR && termLeft == 2'd0)
            termLeft <= cfgCrLf ? 2'd2 : 2'd1;
         if (wrPending && wrAddr == `SLPC_ERRSEND_ADDR) begin
            errPending <= 1'b1;
            errByte <= hwdata[7:0];
         end
         if (rxGood && rxParBad && serviceRequestEnable)
            eventPending <= 1'b1;
      end
   end

   // Transmitter, least significant bit first
   always @(posedge clk) begin
      if (sys_rst) begin
         txState <= TX_IDLE;
         txShift <= 11'h7ff;
         txBits <= 4'd0;
         txTicks <= 4'd0;
         txIsStatus <= 1'b0;
         txd <= 1'b1;
         requestActive <= 1'b0;
      end else begin
         case (txState)
            TX_IDLE: begin
               txd <= 1'b1;
               requestActive <= 1'b0;
               if (txStart) begin
                  txShift <= {2'b11, txBitsOut, 1'b0};
                  txBits <= twoStop ? 4'd11 : 4'd10;
                  txTicks <= 4'd0;
                  txIsStatus <= errPending || eventPending;
                  txState <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               txd <= txShift[0];
               requestActive <= txIsStatus;
               if (tick) begin
                  if (txTicks == 4'd15) begin
                     txTicks <= 4'd0;
                     txShift <= {1'b1, txShift[10:1]};
                     if (txBits == 4'd1)
                        txState <= TX_IDLE;
                     txBits <= txBits - 4'd1;
                  end else begin
                     txTicks <= txTicks + 4'd1;
                  end
               end
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end

   // Receiver, centre sampling from the start edge
   always @(posedge clk) begin
      if (sys_rst) begin
         rxState <= RX_IDLE;
         rxShift <= 8'h0;
         rxBits <= 3'd0;
         rxTicks <= 4'd0;
         rxPrev <= 1'b1;
      end else if (tick) begin
         rxPrev <= rxd;
         case (rxState)
            RX_IDLE: begin
               rxTicks <= 4'd0;
               if (rxPrev && !rxd)
                  rxState <= RX_START;
            end
            RX_START: begin
               if (rxTicks == 4'd7) begin
                  rxTicks <= 4'd0;
                  rxBits <= 3'd0;
                  rxState <= rxd ? RX_IDLE : RX_DATA;
               end else begin
                  rxTicks <= rxTicks + 4'd1;
               end
            end
            RX_DATA: begin
               if (rxTicks == 4'd15) begin
                  rxTicks <= 4'd0;
                  rxShift <= {rxd, rxShift[7:1]};
                  rxBits <= rxBits + 3'd1;
                  if (rxBits == 3'd7)
                     rxState <= RX_STOP;
               end else begin
                  rxTicks <= rxTicks + 4'd1;
               end
            end
            RX_STOP: begin
               if (rxTicks == 4'd15) begin
                  rxTicks <= 4'd0;
                  rxState <= RX_IDLE;
               end else begin
                  rxTicks <= rxTicks + 4'd1;
               end
            end
            default: rxState <= RX_IDLE;
         endcase
      end
   end

   // Received character delivery and status flags; set wins over clear
   always @(posedge clk) begin
      if (sys_rst) begin
         rxValid <= 1'b0;
         rxData <= 8'h0;
         parErr <= 1'b0;
         frameErr <= 1'b0;
         lineEnd <= 1'b0;
         overrun <= 1'b0;
         paused <= 1'b0;
      end else begin
         if (addrPhase && !hwrite && haddr == `SLPC_RXDATA_ADDR)
            rxValid <= 1'b0;
         if (wrPending && wrAddr == `SLPC_STAT_ADDR) begin
            if (hwdata[`SLPC_ST_PARERR])
               parErr <= 1'b0;
            if (hwdata[`SLPC_ST_FRAMEERR])
               frameErr <= 1'b0;
            if (hwdata[`SLPC_ST_LINEEND])
               lineEnd <= 1'b0;
            if (hwdata[`SLPC_ST_OVERRUN])
               overrun <= 1'b0;
         end
         if (!flowEnable)
            paused <= 1'b0;
         if (rxDone && !rxd)
            frameErr <= 1'b1;
         if (rxGood) begin
            if (rxParBad)
               parErr <= 1'b1;
            if (rxFlowChar) begin
               paused <= (rxChar == `SLPC_CHAR_XOFF);
            end else begin
               rxValid <= 1'b1;
               rxData <= rxChar;
               if (rxValid)
                  overrun <= 1'b1;
               if (rxLineEnd)
                  lineEnd <= 1'b1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: slpc_serial_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "slpc_map.vh"
module slpc_serial_port_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [3:0] swBaud,
   input wire logic swParEnable,
   input wire logic [1:0] swParSelect,
   input wire logic swCrLf,
   input wire logic [1:0] swHardcopy,
   input wire logic txd,
   input wire logic requestActive
);
   localparam int BIT = 5216;
   logic capped;
   logic [3:0] capBaud;
   logic [9:0] capCfg;
   logic inFrame;
   int lowRun;
   int fcnt;
   // Switch capture and frame tracking
   always @(posedge clk) begin
      if (sys_rst) begin
         capped <= 1'b0;
         inFrame <= 1'b0;
         lowRun <= 0;
         fcnt <= 0;
      end else begin
         lowRun <= txd ? 0 : lowRun + 1;
         if (!capped) begin
            capped <= 1'b1;
            capBaud <= swBaud;
            capCfg <= {swHardcopy, swBaud[3], swCrLf, swParSelect, swParEnable, swBaud[2:0]};
         end
         if (inFrame) begin
            fcnt <= fcnt + 1;
            if (fcnt == 10 * BIT - 1)
               inFrame <= 1'b0;
         end else if (capped && capBaud == 4'he && !txd) begin
            inFrame <= 1'b1;
            fcnt <= 1;
         end
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_read(logic [7:0] a);
      capped && hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence
   a_zero_wait: assert property (hreadyout && !hresp)
      else $error("bus answer not zero wait OKAY");
   a_reset_idle: assert property ($fell(sys_rst) |-> txd && !requestActive && hrdata == 32'h0)
      else $error("outputs not idle after reset");
   a_offline_quiet: assert property (capped && capBaud == `SLPC_OFFLINE_CODE |-> txd && !requestActive)
      else $error("line active while off line");
   a_config_read: assert property (s_read(`SLPC_CONFIG_ADDR) |=> hrdata[9:0] == capCfg)
      else $error("config differs from captured switches");
   a_graph_prefix: assert property (s_read(`SLPC_GRAPH_ADDR) |=>
      hrdata == {16'h0, `SLPC_CHAR_ESC, capCfg[3] ? `SLPC_CHAR_L : `SLPC_CHAR_Y})
      else $error("graphics prefix wrong");
   a_start_bit: assert property (inFrame && fcnt == BIT / 2 |-> !txd)
      else $error("start bit not low at centre");
   a_stop_bit: assert property (inFrame && fcnt == 9 * BIT + BIT / 2 |-> txd)
      else $error("stop bit not high at centre");
   a_bit_timing: assert property (capped && capBaud == 4'he && $rose(txd) |-> lowRun % BIT == 0)
      else $error("low run not whole bit periods");
endmodule
bind slpc_serial_port slpc_serial_port_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .swBaud(swBaud), .swParEnable(swParEnable),
   .swParSelect(swParSelect), .swCrLf(swCrLf), .swHardcopy(swHardcopy), .txd(txd),
   .requestActive(requestActive));
`default_nettype wire

// File: slpc_host_link.sv
`timescale 1ns/1ns
`default_nettype none
module slpc_host_link #(
   parameter int BIT_CLKS = 5216
) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] lastRx = 8'h00;
   logic stopOk = 1'b0;
   int rxCount = 0;
   int k;
   initial rxd = 1'b1;
   // Sends start, eight bits, one stop
   task send_char(input logic [7:0] ch);
      int i;
      rxd <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         rxd <= ch[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask
   // Samples each bit at its centre
   always begin
      @(posedge clk);
      if (txd === 1'b0) begin
         repeat (BIT_CLKS / 2) @(posedge clk);
         for (k = 0; k < 8; k++) begin
            repeat (BIT_CLKS) @(posedge clk);
            lastRx[k] = txd;
         end
         repeat (BIT_CLKS) @(posedge clk);
         stopOk = (txd === 1'b1);
         rxCount++;
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "slpc_map.vh"
module testbench;
   localparam int BIT = 5216;
   logic clk = 1'b0;
   logic sysRst, hsel, hwrite, swParEnable, swCrLf;
   logic [7:0] haddr;
   logic [1:0] htrans, swParSelect, swHardcopy;
   logic [2:0] hsize;
   logic [31:0] hwdata, rd, cfgExp;
   logic [3:0] swBaud;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, rxd, txd, requestActive;
   int miscompares = 0;
   int cmp_count = 0;
   always #10 clk = ~clk;
   slpc_serial_port dut_u (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .swBaud(swBaud), .swParEnable(swParEnable),
      .swParSelect(swParSelect), .swCrLf(swCrLf), .swHardcopy(swHardcopy), .rxd(rxd), .txd(txd),
      .requestActive(requestActive));
   slpc_host_link #(.BIT_CLKS(BIT)) host_u (.clk(clk), .txd(txd), .rxd(rxd));
   task check32(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task bus_wait;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
   endtask
   task ahb_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      bus_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      bus_wait();
      rd = hrdata;
   endtask
   task expect_read(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb_access(1'b0, a, 32'h0);
      check32(name, exp, rd);
   endtask
   task do_reset;
      sysRst <= 1'b1;
      repeat (20) @(posedge clk);
      sysRst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   initial begin
      sysRst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      swBaud = 4'he;
      swParEnable = 1'b1;
      swParSelect = 2'b01;
      swCrLf = 1'b1;
      swHardcopy = 2'b01;
      @(posedge clk);
      do_reset();
      cfgExp = {22'h0, swHardcopy, swBaud[3], swCrLf, swParSelect, swParEnable, swBaud[2:0]};
      swBaud <= 4'h0;
      swParSelect <= 2'b10;
      swHardcopy <= 2'b11;
      expect_read("config", `SLPC_CONFIG_ADDR, cfgExp);
      expect_read("ctrl", `SLPC_CTRL_ADDR, 32'h10);
      expect_read("graph", `SLPC_GRAPH_ADDR, 32'h1b4c);
      ahb_access(1'b1, `SLPC_CTRL_ADDR, 32'h11);
      expect_read("ctrl", `SLPC_CTRL_ADDR, 32'h11);
      expect_read("unmapped", 8'h40, 32'h0);
      fork
         host_u.send_char(8'h45);
         begin
            ahb_access(1'b1, `SLPC_TXDATA_ADDR, 32'h43);
            repeat (BIT / 8) @(posedge clk);
            expect_read("busy", `SLPC_STAT_ADDR, 32'h01);
            check32("request", 32'h0, {31'h0, requestActive});
            repeat (12 * BIT) begin
               if (host_u.rxCount == 1)
                  break;
               @(posedge clk);
            end
         end
      join
      check32("txFrame", 32'hc3, {24'h0, host_u.lastRx});
      check32("stop", 32'h1, {31'h0, host_u.stopOk});
      repeat (BIT) @(posedge clk);
      expect_read("status", `SLPC_STAT_ADDR, 32'h06);
      expect_read("rxdata", `SLPC_RXDATA_ADDR, 32'h45);
      expect_read("status", `SLPC_STAT_ADDR, 32'h04);
      ahb_access(1'b1, `SLPC_STAT_ADDR, 32'h04);
      expect_read("status", `SLPC_STAT_ADDR, 32'h00);
      ahb_access(1'b1, `SLPC_CTRL_ADDR, 32'h10);
      expect_read("ctrl", `SLPC_CTRL_ADDR, 32'h10);
      swBaud <= `SLPC_OFFLINE_CODE;
      swParEnable <= 1'b0;
      swParSelect <= 2'b11;
      swCrLf <= 1'b0;
      swHardcopy <= 2'b10;
      do_reset();
      expect_read("graph", `SLPC_GRAPH_ADDR, 32'h1b59);
      expect_read("ctrl", `SLPC_CTRL_ADDR, 32'h20);
      ahb_access(1'b1, `SLPC_TXDATA_ADDR, 32'h55);
      repeat (BIT) @(posedge clk);
      check32("frames", 32'h1, 32'(host_u.rxCount));
      expect_read("status", `SLPC_STAT_ADDR, 32'h20);
      wrap_up();
   end
endmodule
`default_nettype wire
